//--- shared/lin_cfg.svh
// Purpose: Constants for the transceiver control block: times, derived cycle counts, resets.
// Assumes: Core clock mclk_in at 10 MHz; every time is given in microseconds.
// Notes: Minimum times round up to whole cycles, and none is shorter than one cycle.
`ifndef LIN_CFG_SVH
`define LIN_CFG_SVH

`define LIN_CLK_KHZ 10000
`define LIN_WAKE_DOM_US 150
`define LIN_WAKE_DOM_CYC ((`LIN_WAKE_DOM_US * `LIN_CLK_KHZ + 999) / 1000 + 1)
`define LIN_MASK_US 25
`define LIN_MASK_CYC ((`LIN_MASK_US * `LIN_CLK_KHZ + 999) / 1000)
`define LIN_DOM_TOUT_US 10000
`define LIN_DOM_TOUT_CYC ((`LIN_DOM_TOUT_US * `LIN_CLK_KHZ + 999) / 1000)
`define LIN_SETTLE_CYC 3'h4
`define LIN_SYNC_W 4
`define LIN_SYNC_RESET 4'h7
`define LIN_SYNC_TXD 0
`define LIN_SYNC_BUS 1
`define LIN_SYNC_LINE 2
`define LIN_SYNC_SHORT 3
`define LIN_TIMER_W 24

`endif

//--- shared/lin_pkg.sv
// Purpose: Types shared by the transceiver control modules.
// Assumes: Included after nothing else; holds types only.
// Notes: Constant values live in lin_cfg.svh.
package lin_pkg;
  typedef enum logic [0:0] {
    mode_active,
    mode_sleep
  } mode_type;
endpackage

//--- shared/timer_if.sv
// Purpose: Carrier between the control logic and one interval timer.
// Assumes: The user side holds run high for as long as the interval is to be measured.
// Notes: Dropping run clears the count.
`timescale 1ns/1ps
interface timer_if #(
  parameter int W = 24
);
  logic run;
  logic [W-1:0] limit;
  logic expired;
  modport timer (input run, input limit, output expired);
  modport user (output run, output limit, input expired);
endinterface

//--- rtl/lin_pin_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherency is implied.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`include "lin_cfg.svh"
module lin_pin_sync
  import lin_pkg::*;
#(
  parameter int W = `LIN_SYNC_W,
  parameter logic [W-1:0] RESET_VAL = `LIN_SYNC_RESET
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_nxt;

  always_comb begin
    stage1_nxt = async_in;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sync_out = stage2_r;
endmodule

//--- rtl/lin_interval_timer.sv
// Purpose: Saturating interval counter that flags once run has stood for limit cycles.
// Assumes: limit is at least one.
// Notes: expired is registered and falls in the cycle after run falls.
`timescale 1ns/1ps
`include "lin_cfg.svh"
module lin_interval_timer
  import lin_pkg::*;
#(
  parameter int W = `LIN_TIMER_W
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  timer_if.timer t
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic expired_r;
  logic expired_nxt;

  always_comb begin
    count_nxt = '0;
    if (t.run) begin
      count_nxt = (count_r >= t.limit) ? count_r : count_r + 1'b1;
    end
    expired_nxt = t.run && (count_nxt >= t.limit);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
      expired_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign t.expired = expired_r;
endmodule

//--- rtl/lin_transceiver_control.sv
// Purpose: Digital control of the bus transmitter, fault/enable line and Sleep wake-up.
// Assumes: Pins arrive asynchronously; sleep_req_in comes from logic on mclk_in.
// Notes: The fault/enable line is open-drain; the wire level is resolved outside.
`timescale 1ns/1ps
`include "lin_cfg.svh"
module lin_transceiver_control
  import lin_pkg::*;
#(
  parameter int TIMER_W = `LIN_TIMER_W,
  parameter int DOM_TOUT_CYCLES = `LIN_DOM_TOUT_CYC,
  parameter int WAKE_CYCLES = `LIN_WAKE_DOM_CYC,
  parameter int MASK_CYCLES = `LIN_MASK_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic txd_in,
  input wire logic bus_sense_in,
  input wire logic fault_txen_line_in,
  input wire logic short_detect_in,
  input wire logic sleep_req_in,
  output logic fault_txen_line_out,
  output logic fault_txen_line_oe_n_out,
  output logic rxd_out,
  output logic bus_drive_out,
  output logic tx_enable_out,
  output logic mismatch_fault_out,
  output logic short_fault_out,
  output logic timeout_fault_out,
  output logic host_override_out,
  output logic sleep_out,
  output logic wake_out
);
  logic [`LIN_SYNC_W-1:0] pins_async;
  logic [`LIN_SYNC_W-1:0] pins_sync;
  logic txd_s;
  logic bus_s;
  logic line_s;
  logic short_s;

  // Pin levels pass two flip-flops before anything looks at them.
  assign pins_async[`LIN_SYNC_TXD] = txd_in;
  assign pins_async[`LIN_SYNC_BUS] = bus_sense_in;
  assign pins_async[`LIN_SYNC_LINE] = fault_txen_line_in;
  assign pins_async[`LIN_SYNC_SHORT] = short_detect_in;

  lin_pin_sync #(
    .W(`LIN_SYNC_W),
    .RESET_VAL(`LIN_SYNC_RESET)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign txd_s = pins_sync[`LIN_SYNC_TXD];
  assign bus_s = pins_sync[`LIN_SYNC_BUS];
  assign line_s = pins_sync[`LIN_SYNC_LINE];
  assign short_s = pins_sync[`LIN_SYNC_SHORT];

  timer_if #(.W(TIMER_W)) mask_t ();
  timer_if #(.W(TIMER_W)) dom_t ();
  timer_if #(.W(TIMER_W)) wake_t ();

  lin_interval_timer #(.W(TIMER_W)) u_mask_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .t(mask_t)
  );

  lin_interval_timer #(.W(TIMER_W)) u_dom_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .t(dom_t)
  );

  lin_interval_timer #(.W(TIMER_W)) u_wake_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .t(wake_t)
  );

  // Mode group: Active or Sleep, with a one-cycle wake pulse.
  mode_type mode_r;
  mode_type mode_nxt;
  logic bus_prev_r;
  logic bus_prev_nxt;
  logic wake_r;
  logic wake_nxt;
  logic active;

  assign active = (mode_r == mode_active);

  // The wake timer runs only while the bus sits dominant during Sleep.
  assign wake_t.run = (mode_r == mode_sleep) && !bus_s;
  assign wake_t.limit = TIMER_W'(WAKE_CYCLES);

  always_comb begin
    mode_nxt = mode_r;
    wake_nxt = 1'b0;
    bus_prev_nxt = bus_s;
    unique case (mode_r)
      mode_active: begin
        if (sleep_req_in) begin
          mode_nxt = mode_sleep;
        end
      end
      mode_sleep: begin
        // A rising edge wakes only if the preceding dominant phase was long enough.
        if (!bus_prev_r && bus_s && wake_t.expired) begin
          mode_nxt = mode_active;
          wake_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= mode_active;
      wake_r <= 1'b0;
      bus_prev_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      wake_r <= wake_nxt;
      bus_prev_r <= bus_prev_nxt;
    end
  end

  // Both transmit timers measure how long the transmit input has been low.
  assign mask_t.run = active && !txd_s;
  assign mask_t.limit = TIMER_W'(MASK_CYCLES);
  assign dom_t.run = active && !txd_s;
  assign dom_t.limit = TIMER_W'(DOM_TOUT_CYCLES);

  // Fault group: registered causes, line pull, settle window and transmitter gating.
  logic mismatch_r;
  logic mismatch_nxt;
  logic short_r;
  logic short_nxt;
  logic dom_lock_r;
  logic dom_lock_nxt;
  logic pull_r;
  logic pull_nxt;
  logic [2:0] settle_r;
  logic [2:0] settle_nxt;
  logic tx_en_r;
  logic tx_en_nxt;
  logic drive_r;
  logic drive_nxt;
  logic rxd_r;
  logic rxd_nxt;
  logic override_r;
  logic override_nxt;
  logic settled;
  logic host_low;

  // The sensed line lags our own pull by the synchroniser, so its level is only
  // trusted once the settle window after each change of pull has run out.
  assign settled = (settle_r == 3'h0);

  // Line low while we release it can only be the host switching the transmitter off.
  assign host_low = settled && !pull_r && !line_s;

  always_comb begin
    mismatch_nxt = 1'b0;
    short_nxt = 1'b0;
    dom_lock_nxt = dom_lock_r;
    if (active) begin
      // Transmit low while the bus stays recessive is contention or a short to supply;
      // the first part of each low phase is masked to cover bus propagation.
      mismatch_nxt = !txd_s && bus_s && mask_t.expired && !host_low;
      short_nxt = short_s && !host_low;
      if (!txd_s && dom_t.expired) begin
        dom_lock_nxt = 1'b1;
      end else if (txd_s) begin
        dom_lock_nxt = 1'b0;
      end
    end else begin
      dom_lock_nxt = 1'b0;
    end

    // Any fault pulls the open-drain line; it is released once all have cleared.
    pull_nxt = mismatch_nxt || short_nxt || dom_lock_nxt;

    if (pull_nxt != pull_r) begin
      settle_nxt = `LIN_SETTLE_CYC;
    end else if (!settled) begin
      settle_nxt = settle_r - 3'h1;
    end else begin
      settle_nxt = settle_r;
    end

    // The transmitter follows the line level: a host holding it high overrules
    // mismatch and short, but never a dominant time-out.
    tx_en_nxt = active && line_s && (settle_nxt == 3'h0) && !dom_lock_nxt;

    override_nxt = pull_nxt && (settle_nxt == 3'h0) && line_s && !dom_lock_nxt;

    // The driver is dominant only while enabled and transmitting a low.
    drive_nxt = tx_en_nxt && !txd_s;

    rxd_nxt = bus_s;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mismatch_r <= 1'b0;
      short_r <= 1'b0;
      dom_lock_r <= 1'b0;
      pull_r <= 1'b0;
      settle_r <= `LIN_SETTLE_CYC;
      tx_en_r <= 1'b0;
      drive_r <= 1'b0;
      rxd_r <= 1'b1;
      override_r <= 1'b0;
    end else begin
      mismatch_r <= mismatch_nxt;
      short_r <= short_nxt;
      dom_lock_r <= dom_lock_nxt;
      pull_r <= pull_nxt;
      settle_r <= settle_nxt;
      tx_en_r <= tx_en_nxt;
      drive_r <= drive_nxt;
      rxd_r <= rxd_nxt;
      override_r <= override_nxt;
    end
  end

  // The line is only ever pulled low or released, never driven high.
  assign fault_txen_line_out = 1'b0;
  assign fault_txen_line_oe_n_out = !pull_r;
  assign rxd_out = rxd_r;
  assign bus_drive_out = drive_r;
  assign tx_enable_out = tx_en_r;
  assign mismatch_fault_out = mismatch_r;
  assign short_fault_out = short_r;
  assign timeout_fault_out = dom_lock_r;
  assign host_override_out = override_r;
  assign sleep_out = (mode_r == mode_sleep);
  assign wake_out = wake_r;
endmodule

//--- tb/lin_control_assertions.sv
// Purpose: Port-level checker for lin_transceiver_control.
// Assumes: Counts are in mclk_in cycles and match the bound instance.
// Notes: Helper counters hold run lengths of low txd and of a dominant bus.
`timescale 1ns/1ps
module lin_control_assertions #(
  parameter int DOM_TOUT_CYCLES = 100000,
  parameter int WAKE_CYCLES = 1501,
  parameter int MASK_CYCLES = 250
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic txd_in,
  input wire logic bus_sense_in,
  input wire logic fault_txen_line_in,
  input wire logic fault_txen_line_out,
  input wire logic fault_txen_line_oe_n_out,
  input wire logic rxd_out,
  input wire logic tx_enable_out,
  input wire logic mismatch_fault_out,
  input wire logic short_fault_out,
  input wire logic timeout_fault_out,
  input wire logic host_override_out,
  input wire logic wake_out,
  input wire logic sleep_out
);
  logic [23:0] tx_low_r, tx_low_nxt, bus_low_r, bus_low_nxt, run_r, run_nxt;
  always_comb begin
    tx_low_nxt = txd_in ? 24'h0 : tx_low_r + 24'h1;
    bus_low_nxt = bus_sense_in ? 24'h0 : bus_low_r + 24'h1;
    run_nxt = (bus_sense_in && bus_low_r != 24'h0) ? bus_low_r : run_r;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_low_r <= 24'h0;
      bus_low_r <= 24'h0;
      run_r <= 24'h0;
    end else begin
      tx_low_r <= tx_low_nxt;
      bus_low_r <= bus_low_nxt;
      run_r <= run_nxt;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_line_low_off: assert property ((!fault_txen_line_in)[*4] |-> !tx_enable_out)
    else $error("transmitter on while line low");
  a_rxd_follows: assert property ($past(rst_n_in, 3) |-> rxd_out == $past(bus_sense_in, 3))
    else $error("rxd does not follow bus");
  a_mismatch_pulls: assert property (mismatch_fault_out[*2] |-> !fault_txen_line_oe_n_out)
    else $error("mismatch without pull");
  a_short_pulls: assert property (short_fault_out[*2] |-> !fault_txen_line_oe_n_out)
    else $error("short without pull");
  a_override_keeps_on: assert property ((host_override_out && !timeout_fault_out)[*3] |-> tx_enable_out)
    else $error("override did not enable");
  a_timeout_off: assert property (timeout_fault_out[*2] |-> !tx_enable_out)
    else $error("transmitter on after time-out");
  a_timeout_holds: assert property ((!txd_in)[*3] ##0 timeout_fault_out |=> timeout_fault_out)
    else $error("time-out dropped while txd low");
  a_timeout_late: assert property ($rose(timeout_fault_out) |-> tx_low_r >= DOM_TOUT_CYCLES)
    else $error("time-out too early");
  a_mask_late: assert property ($rose(mismatch_fault_out) |-> tx_low_r >= MASK_CYCLES)
    else $error("mismatch reported too early");
  a_wake_after_dom: assert property (wake_out |-> run_r >= WAKE_CYCLES ##1 (!wake_out && !sleep_out))
    else $error("bad wake");
  a_host_low_quiet: assert property ((!fault_txen_line_in && fault_txen_line_oe_n_out)[*4]
    |-> !mismatch_fault_out && !short_fault_out)
    else $error("host low taken as fault");
  a_open_drain: assert property (fault_txen_line_out == 1'b0)
    else $error("line driven high");
  c_wake: cover property (wake_out);
  c_override: cover property (host_override_out);
  c_timeout: cover property ($rose(timeout_fault_out));
endmodule
bind lin_transceiver_control lin_control_assertions #(
  .DOM_TOUT_CYCLES(DOM_TOUT_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES),
  .MASK_CYCLES(MASK_CYCLES)
) i_chk (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .txd_in(txd_in),
  .bus_sense_in(bus_sense_in),
  .fault_txen_line_in(fault_txen_line_in),
  .fault_txen_line_out(fault_txen_line_out),
  .fault_txen_line_oe_n_out(fault_txen_line_oe_n_out),
  .rxd_out(rxd_out),
  .tx_enable_out(tx_enable_out),
  .mismatch_fault_out(mismatch_fault_out),
  .short_fault_out(short_fault_out),
  .timeout_fault_out(timeout_fault_out),
  .host_override_out(host_override_out),
  .wake_out(wake_out),
  .sleep_out(sleep_out)
);

//--- tb/lin_host_model.sv
// Purpose: Host side of the fault/enable line, with the wire level resolved.
// Assumes: host_mode_in 0 = released, 1 = drives high, 2 = drives low.
// Notes: A host driving high overrules the device pull-down.
`timescale 1ns/1ps
module lin_host_model (
  input wire logic [1:0] host_mode_in,
  input wire logic oe_n_in,
  output logic line_out
);
  always_comb begin
    case (host_mode_in)
      2'h1: line_out = 1'b1;
      2'h2: line_out = 1'b0;
      default: line_out = oe_n_in;
    endcase
  end
endmodule

//--- tb/lin_transceiver_control_tb.sv
// Purpose: Self-checking bench for lin_transceiver_control.
// Assumes: Shortened counts; bus model registers the wired-and of bus and driver.
// Notes: Rows pack txd,bus,stuck,short / host / en,oe_n,rxd,mismatch.
`timescale 1ns/1ps
module lin_transceiver_control_tb;
  localparam int DOM = 200;
  localparam int WAKE = 20;
  logic mclk_in = 0, rst_n_in = 0, txd = 1, bus_ext = 1, stuck = 0, shrt = 0, slp = 0;
  logic bus_sense = 1, line, od, oe_n, rxd, drv, en, mism, sf, tof, ovr, sleep, wake;
  logic [1:0] host = 2'h0;
  logic [9:0] rows [8] = '{10'b1100_00_1110, 10'b1000_00_1100, 10'b0100_00_1100,
    10'b0110_00_0011, 10'b0110_01_1011, 10'b0110_10_0110, 10'b1101_00_0010, 10'b1101_01_1010};
  int n_mismatch = 0, checks_done = 0, k;
  always #50 mclk_in = ~mclk_in;
  // The bus goes dominant when the device drives it unless shorted high.
  always @(posedge mclk_in) bus_sense <= stuck | (bus_ext & ~drv);
  lin_host_model i_host (.host_mode_in(host), .oe_n_in(oe_n), .line_out(line));
  lin_transceiver_control #(.DOM_TOUT_CYCLES(DOM), .WAKE_CYCLES(WAKE), .MASK_CYCLES(10)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .txd_in(txd), .bus_sense_in(bus_sense),
    .fault_txen_line_in(line), .short_detect_in(shrt), .sleep_req_in(slp),
    .fault_txen_line_out(od), .fault_txen_line_oe_n_out(oe_n), .rxd_out(rxd),
    .bus_drive_out(drv), .tx_enable_out(en), .mismatch_fault_out(mism),
    .short_fault_out(sf), .timeout_fault_out(tof), .host_override_out(ovr),
    .sleep_out(sleep), .wake_out(wake));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %b seen %b", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    tick(2);
    chk("en in reset", 1'b0, en);
    chk("oe_n in reset", 1'b1, oe_n);
    tick(1);
    rst_n_in <= 1;
    tick(10);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      {txd, bus_ext, stuck, shrt, host} <= rows[i][9:4];
      tick(40);
      chk("en", rows[i][3], en);
      chk("oe_n", rows[i][2], oe_n);
      chk("rxd", rows[i][1], rxd);
      chk("mismatch", rows[i][0], mism);
      chk("short", shrt && host != 2'h2, sf);
      chk("override", host == 2'h1 && !rows[i][2], ovr);
      chk("drive", !rows[i][9] && rows[i][3], drv);
      {txd, bus_ext, stuck, shrt, host} <= 6'b110000;
      tick(15);
      $display("test row %0d done", i);
    end
    stuck <= 1;
    txd <= 0;
    tick(8);
    chk("mismatch masked", 1'b0, mism);
    tick(12);
    chk("mismatch late", 1'b1, mism);
    {txd, stuck} <= 2'b10;
    tick(15);
    $display("test mask done");
    txd <= 0;
    tick(DOM + 20);
    chk("timeout", 1'b1, tof);
    chk("en timeout", 1'b0, en);
    chk("drive timeout", 1'b0, drv);
    host <= 2'h1;
    tick(10);
    chk("en forced", 1'b0, en);
    txd <= 1;
    host <= 2'h0;
    tick(20);
    chk("timeout clear", 1'b0, tof);
    chk("en again", 1'b1, en);
    $display("test timeout done");
    slp <= 1;
    tick(1);
    slp <= 0;
    tick(3);
    chk("sleep", 1'b1, sleep);
    bus_ext <= 0;
    tick(WAKE / 2);
    bus_ext <= 1;
    tick(10);
    chk("no early wake", 1'b1, sleep);
    bus_ext <= 0;
    tick(WAKE + 10);
    bus_ext <= 1;
    k = 0;
    while (wake !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    chk("wake", 1'b1, wake);
    tick(1);
    chk("awake", 1'b0, sleep);
    $display("test wake done");
    give_verdict();
  end
endmodule
